// ==== rtl/mia_pkg.sv ====
// constants shared by the motion interrupt unit and its pin and counter modules
// assumes one 40 MHz core clock and an active-low asynchronous core reset
package mia_pkg;

  // default widths of the sample path and programmed settings
  localparam int DATA_W_DEF = 16;
  localparam int THR_W_DEF  = 16;
  localparam int DUR_W_DEF  = 13;

  // event positions in the routing vectors
  localparam int EV_ACT   = 0;
  localparam int EV_STILL = 1;
  localparam int EV_FULL  = 2;
  localparam int EV_WTM   = 3;
  localparam int EV_DRDY  = 4;
  localparam int EV_N     = 5;

  // flag positions inside the two status words
  localparam int FEAT_ACT   = 0;
  localparam int FEAT_STILL = 1;
  localparam int FEAT_N     = 2;
  localparam int BUF_FULL   = 0;
  localparam int BUF_WTM    = 1;
  localparam int BUF_DRDY   = 2;
  localparam int BUF_N      = 3;

  // encodings of the single-bit settings
  localparam logic DRV_OPEN_DRAIN = 1'h1;
  localparam logic DRV_PUSH_PULL  = 1'h0;
  localparam logic POL_ACT_HIGH   = 1'h1;
  localparam logic SENSE_EDGE     = 1'h1;
  localparam logic HOLD_LATCHED   = 1'h1;

  // reset values
  localparam logic RST_BIT = 1'h0;

endpackage : mia_pkg

// ==== rtl/mia_run_count.sv ====
// run-length counter of consecutive qualifying samples for one motion detector
// assumes tick is a one-cycle pulse per new sample on the same clock
`timescale 1ns/1ps
module mia_run_count
  import mia_pkg::*;
#(
  parameter int DUR_W = DUR_W_DEF
)
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             tick,
  input  wire logic             cond,
  input  wire logic [DUR_W-1:0] dur,
  output logic                  reached
);

  typedef struct packed {
    logic [DUR_W-1:0] cnt;
  } mia_run_st_t;

  mia_run_st_t st_r;
  mia_run_st_t st_nxt;
  logic [DUR_W:0] cnt_inc;

  if (DUR_W < 1)
  begin : g_chk
    $error("mia_run_count: DUR_W must be at least 1");
  end

  always_comb
  begin
    st_nxt  = st_r;
    cnt_inc = {1'h0, st_r.cnt} + {{DUR_W{1'h0}}, 1'h1};
    // a duration of zero behaves as one sample
    reached = tick & cond & (cnt_inc >= {1'h0, dur});
    if (tick)
    begin
      if (!cond)
        st_nxt.cnt = '0;
      else if (!cnt_inc[DUR_W])
        st_nxt.cnt = cnt_inc[DUR_W-1:0]; // saturates instead of wrapping back to a short run
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule : mia_run_count

// ==== rtl/mia_pin_ctl.sv ====
// electrical control and input sensing of one interrupt pin
// assumes the pin arrives asynchronously; the wire level is resolved outside from out and oe
`timescale 1ns/1ps
module mia_pin_ctl
  import mia_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic irq,
  input  wire logic drive_en,
  input  wire logic drive_type,
  input  wire logic polarity,
  input  wire logic sense_en,
  input  wire logic sense_edge,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      sensed
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic asrt_d;
    logic out;
    logic oe;
    logic sensed;
    logic [1:0] fill;
  } mia_pin_st_t;

  mia_pin_st_t st_r;
  mia_pin_st_t st_nxt;
  logic        lvl;
  logic        inner;

  always_comb
  begin
    st_nxt       = st_r;
    lvl          = (polarity == POL_ACT_HIGH) ? irq : ~irq;
    st_nxt.sync1 = pin_in;
    st_nxt.sync2 = st_r.sync1;
    if (drive_type == DRV_OPEN_DRAIN)
    begin
      st_nxt.out = 1'h0;
      st_nxt.oe  = drive_en & ~lvl;
    end
    else
    begin
      st_nxt.out = lvl;
      st_nxt.oe  = drive_en;
    end
    // own output loops back so no wire round trip is needed
    inner         = (drive_en & sense_en) ? irq : (st_r.sync2 == polarity);
    st_nxt.asrt_d = sense_en & inner;
    if (sense_edge == SENSE_EDGE)
      st_nxt.sensed = sense_en & inner & ~st_r.asrt_d;
    else
      st_nxt.sensed = sense_en & inner;
    // synchroniser holds reset zeros for two edges; an active-low pin would look asserted
    st_nxt.fill = {st_r.fill[0], 1'h1};
    if (!st_r.fill[1])
    begin
      st_nxt.asrt_d = 1'h0;
      st_nxt.sensed = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign pin_out = st_r.out;
  assign pin_oe  = st_r.oe;
  assign sensed  = st_r.sensed;

  pin_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    !drive_en |=> !pin_oe)
    else $error("pin driven while drive disabled");

  od_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    (drive_type == DRV_OPEN_DRAIN) |=> !pin_out)
    else $error("open drain pin drives high");

endmodule : mia_pin_ctl

// ==== rtl/mia_motion_irq.sv ====
// activity and stillness detectors with status flags and routing onto two interrupt pins
// assumes samples, thresholds and buffer conditions come from logic on CLK; pins are asynchronous
`timescale 1ns/1ps
// Summary of operation
// - activity slope per axis is newest sample minus stored reference sample
// - activity fires when any armed axis slope exceeds threshold for duration samples
// - reference sample is replaced only when activity fires
// - activity status drops once slope is no longer above the threshold
// - stillness slope per axis is difference of two successive samples
// - stillness works when at least one of its three axis arm bits is set
// - stillness fires when every armed slope stays below threshold for duration
// - stillness run count restarts whenever any armed slope is not below threshold
// - stillness status clears at once when an armed slope reaches the threshold
// - each pin drives only while its drive enable bit is set
// - drive type one means open drain, zero means push pull
// - polarity chooses high or low level for an asserted pin
// - sensing pin with drive enabled follows the pin's own interrupt output
// - sense trigger type selects edge or level recognition of the pin input
// - hold mode sets latched or not for buffer events; feature events latched until read or until their status drops
// - latched flags clear on status read, releasing pins driven by them
// - cleared latched flag sets again when its condition next rises from inactive
// - non-latched flags and pins follow the condition without any read
// - an event reaches a pin only while its routing bit is set
// - feature flags and buffer or sample-ready flags sit in separate status words
module mia_motion_irq
  import mia_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int THR_W  = THR_W_DEF,
  parameter int DUR_W  = DUR_W_DEF
)
(
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  input  wire logic              SAMPLE_VALID,
  input  wire logic [DATA_W-1:0] ACC_X,
  input  wire logic [DATA_W-1:0] ACC_Y,
  input  wire logic [DATA_W-1:0] ACC_Z,
  input  wire logic [THR_W-1:0]  ACT_THRESHOLD,
  input  wire logic [DUR_W-1:0]  ACT_DURATION,
  input  wire logic              ACT_FIRST_AXIS_ARM,
  input  wire logic              ACT_SECOND_AXIS_ARM,
  input  wire logic              ACT_THIRD_AXIS_ARM,
  input  wire logic [THR_W-1:0]  STILL_THRESHOLD,
  input  wire logic [DUR_W-1:0]  STILL_DURATION,
  input  wire logic              STILL_FIRST_AXIS_ARM,
  input  wire logic              STILL_SECOND_AXIS_ARM,
  input  wire logic              STILL_THIRD_AXIS_ARM,
  input  wire logic              BUF_FULL_COND,
  input  wire logic              BUF_WATERMARK_COND,
  input  wire logic              SAMPLE_READY_COND,
  input  wire logic              HOLD_UNTIL_READ_SEL,
  input  wire logic              FEATURE_FLAGS_READ,
  input  wire logic              BUFFER_FLAGS_READ,
  input  wire logic [EV_N-1:0]   PIN_A_ROUTE_BITS,
  input  wire logic [EV_N-1:0]   PIN_B_ROUTE_BITS,
  input  wire logic              PIN_A_DRIVE_ENABLE,
  input  wire logic              PIN_A_DRIVE_TYPE_SEL,
  input  wire logic              PIN_A_POLARITY,
  input  wire logic              PIN_A_SENSE_ENABLE,
  input  wire logic              PIN_A_SENSE_TRIGGER_TYPE,
  input  wire logic              PIN_B_DRIVE_ENABLE,
  input  wire logic              PIN_B_DRIVE_TYPE_SEL,
  input  wire logic              PIN_B_POLARITY,
  input  wire logic              PIN_B_SENSE_ENABLE,
  input  wire logic              PIN_B_SENSE_TRIGGER_TYPE,
  input  wire logic              IRQ_PIN_A_IN,
  input  wire logic              IRQ_PIN_B_IN,
  output logic                   IRQ_PIN_A_OUT,
  output logic                   IRQ_PIN_A_OE,
  output logic                   IRQ_PIN_B_OUT,
  output logic                   IRQ_PIN_B_OE,
  output logic                   PIN_A_SENSED,
  output logic                   PIN_B_SENSED,
  output logic [FEAT_N-1:0]      FEATURE_EVENT_FLAGS,
  output logic [BUF_N-1:0]       BUFFER_READY_EVENT_FLAGS
);

  typedef struct packed {
    logic [2:0][DATA_W-1:0] refs;
    logic [2:0][DATA_W-1:0] prev;
    logic                   prev_ok;
    logic                   act_stat;
    logic                   still_stat;
    logic [FEAT_N-1:0]      feat;
    logic [BUF_N-1:0]       bufs;
    logic [BUF_N-1:0]       cond_d;
  } mia_core_st_t;

  mia_core_st_t           st_r;
  mia_core_st_t           st_nxt;
  logic [2:0][DATA_W-1:0] smp;
  logic [2:0]             act_arm;
  logic [2:0]             still_arm;
  logic [DATA_W:0]        thr_act;
  logic [DATA_W:0]        thr_still;
  logic                   act_over;
  logic                   still_quiet;
  logic                   still_cond;
  logic                   act_reached;
  logic                   still_reached;
  logic                   act_trig;
  logic [FEAT_N-1:0]      feat_rise;
  logic [BUF_N-1:0]       buf_cond;
  logic [BUF_N-1:0]       buf_rise;
  logic [EV_N-1:0]        ev;
  logic                   irq_a;
  logic                   irq_b;

  if (DATA_W < 2 || THR_W < 1 || THR_W > DATA_W + 1 || DUR_W < 1)
  begin : g_chk
    $error("mia_motion_irq: unsupported width parameters");
  end

  // magnitude of a signed difference; one extra bit keeps full-scale swings exact
  function automatic logic [DATA_W:0] abs_slope(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    logic signed [DATA_W:0] d;
    d = $signed({a[DATA_W-1], a}) - $signed({b[DATA_W-1], b});
    abs_slope = d[DATA_W] ? $unsigned(-d) : $unsigned(d);
  endfunction : abs_slope

  assign smp       = {ACC_Z, ACC_Y, ACC_X};
  assign act_arm   = {ACT_THIRD_AXIS_ARM, ACT_SECOND_AXIS_ARM, ACT_FIRST_AXIS_ARM};
  assign still_arm = {STILL_THIRD_AXIS_ARM, STILL_SECOND_AXIS_ARM, STILL_FIRST_AXIS_ARM};
  assign thr_act   = (DATA_W + 1)'(ACT_THRESHOLD);
  assign thr_still = (DATA_W + 1)'(STILL_THRESHOLD);
  assign buf_cond  = {SAMPLE_READY_COND, BUF_WATERMARK_COND, BUF_FULL_COND};

  always_comb
  begin
    act_over    = 1'h0;
    still_quiet = 1'h1;
    for (int i = 0; i < 3; i++)
    begin
      if (act_arm[i] && (abs_slope(smp[i], st_r.refs[i]) > thr_act))
        act_over = 1'h1;
      if (still_arm[i] && !(abs_slope(smp[i], st_r.prev[i]) < thr_still))
        still_quiet = 1'h0;
    end
    // the first sample after reset has no predecessor and cannot count as still
    still_cond = (|still_arm) & still_quiet & st_r.prev_ok;
  end

  mia_run_count #(
    .DUR_W (DUR_W)
  ) u_act_run (
    .clk     (CLK),
    .reset_n (RESET_N),
    .tick    (SAMPLE_VALID),
    .cond    (act_over),
    .dur     (ACT_DURATION),
    .reached (act_reached)
  );

  mia_run_count #(
    .DUR_W (DUR_W)
  ) u_still_run (
    .clk     (CLK),
    .reset_n (RESET_N),
    .tick    (SAMPLE_VALID),
    .cond    (still_cond),
    .dur     (STILL_DURATION),
    .reached (still_reached)
  );

  always_comb
  begin
    st_nxt   = st_r;
    act_trig = SAMPLE_VALID & act_reached & ~st_r.act_stat;
    if (SAMPLE_VALID)
    begin
      st_nxt.act_stat   = act_over & (st_r.act_stat | act_reached);
      st_nxt.still_stat = still_cond & (st_r.still_stat | still_reached);
      st_nxt.prev       = smp;
      st_nxt.prev_ok    = 1'h1;
      if (act_trig)
        st_nxt.refs = smp;
    end
    feat_rise = {st_nxt.still_stat & ~st_r.still_stat, st_nxt.act_stat & ~st_r.act_stat};
    // feature flags hold until read or until their status drops; a new event in the read cycle still wins
    st_nxt.feat = feat_rise | (st_r.feat & ~{FEAT_N{FEATURE_FLAGS_READ}}
                  & {st_nxt.still_stat, st_nxt.act_stat});
    buf_rise      = buf_cond & ~st_r.cond_d;
    st_nxt.cond_d = buf_cond;
    if (HOLD_UNTIL_READ_SEL == HOLD_LATCHED)
      st_nxt.bufs = buf_rise | (st_r.bufs & ~{BUF_N{BUFFER_FLAGS_READ}});
    else
      st_nxt.bufs = buf_cond;
    // pins take next-state flags so a pin moves in the same cycle as its status word
    ev    = {st_nxt.bufs, st_nxt.feat};
    irq_a = |(ev & PIN_A_ROUTE_BITS);
    irq_b = |(ev & PIN_B_ROUTE_BITS);
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign FEATURE_EVENT_FLAGS      = st_r.feat;
  assign BUFFER_READY_EVENT_FLAGS = st_r.bufs;

  mia_pin_ctl u_pin_a (
    .clk        (CLK),
    .reset_n    (RESET_N),
    .irq        (irq_a),
    .drive_en   (PIN_A_DRIVE_ENABLE),
    .drive_type (PIN_A_DRIVE_TYPE_SEL),
    .polarity   (PIN_A_POLARITY),
    .sense_en   (PIN_A_SENSE_ENABLE),
    .sense_edge (PIN_A_SENSE_TRIGGER_TYPE),
    .pin_in     (IRQ_PIN_A_IN),
    .pin_out    (IRQ_PIN_A_OUT),
    .pin_oe     (IRQ_PIN_A_OE),
    .sensed     (PIN_A_SENSED)
  );

  mia_pin_ctl u_pin_b (
    .clk        (CLK),
    .reset_n    (RESET_N),
    .irq        (irq_b),
    .drive_en   (PIN_B_DRIVE_ENABLE),
    .drive_type (PIN_B_DRIVE_TYPE_SEL),
    .polarity   (PIN_B_POLARITY),
    .sense_en   (PIN_B_SENSE_ENABLE),
    .sense_edge (PIN_B_SENSE_TRIGGER_TYPE),
    .pin_in     (IRQ_PIN_B_IN),
    .pin_out    (IRQ_PIN_B_OUT),
    .pin_oe     (IRQ_PIN_B_OE),
    .sensed     (PIN_B_SENSED)
  );

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  ref_hold_a: assert property (!act_trig |=> $stable(st_r.refs))
    else $error("reference changed without activity trigger");

  ref_load_a: assert property (act_trig |=> st_r.refs == $past(smp))
    else $error("reference not loaded on activity trigger");

  act_rise_a: assert property ($rose(st_r.act_stat) |-> $past(act_over) && $past(SAMPLE_VALID))
    else $error("activity status rose without slope above threshold");

  act_clear_a: assert property (SAMPLE_VALID && !act_over |=> !st_r.act_stat && !FEATURE_EVENT_FLAGS[FEAT_ACT])
    else $error("activity status held after slope fell");

  still_clear_a: assert property (SAMPLE_VALID && !still_quiet |=> !st_r.still_stat)
    else $error("stillness status held after slope rose");

  still_arm_a: assert property (SAMPLE_VALID && still_arm == 3'h0 |=> !st_r.still_stat)
    else $error("stillness status with no armed axis");

  feat_read_a: assert property (FEATURE_FLAGS_READ && feat_rise == '0 |=> FEATURE_EVENT_FLAGS == '0)
    else $error("feature flags survive a status read");

  nolatch_a: assert property (HOLD_UNTIL_READ_SEL != HOLD_LATCHED |=> BUFFER_READY_EVENT_FLAGS == $past(buf_cond))
    else $error("non-latched flags do not follow condition");

  reset_again_a: assert property (HOLD_UNTIL_READ_SEL == HOLD_LATCHED && buf_rise != '0
    |=> (BUFFER_READY_EVENT_FLAGS & $past(buf_rise)) == $past(buf_rise))
    else $error("latched flag lost a new event");

  still_rise_a: assert property ($rose(st_r.still_stat) |-> $past(still_cond) && $past(SAMPLE_VALID))
    else $error("stillness status rose without a quiet sample");

  act_unarmed_a: assert property (SAMPLE_VALID && act_arm == 3'h0
    |=> !st_r.act_stat && !FEATURE_EVENT_FLAGS[FEAT_ACT])
    else $error("activity status with no armed axis");

  no_sample_a: assert property (!SAMPLE_VALID
    |=> $stable(st_r.act_stat) && $stable(st_r.still_stat) && $stable(st_r.prev))
    else $error("detector state moved without a new sample");

  feat_hold_a: assert property (FEATURE_EVENT_FLAGS[FEAT_ACT] && !FEATURE_FLAGS_READ
    && !(SAMPLE_VALID && !act_over) |=> FEATURE_EVENT_FLAGS[FEAT_ACT])
    else $error("activity flag dropped without read or slope fall");

  still_hold_a: assert property (FEATURE_EVENT_FLAGS[FEAT_STILL] && !FEATURE_FLAGS_READ
    && !(SAMPLE_VALID && !still_cond) |=> FEATURE_EVENT_FLAGS[FEAT_STILL])
    else $error("stillness flag dropped without read or slope rise");

  buf_hold_a: assert property (HOLD_UNTIL_READ_SEL == HOLD_LATCHED && !BUFFER_FLAGS_READ
    |=> (BUFFER_READY_EVENT_FLAGS & $past(BUFFER_READY_EVENT_FLAGS)) == $past(BUFFER_READY_EVENT_FLAGS))
    else $error("latched buffer flag dropped without read");

  buf_read_a: assert property (HOLD_UNTIL_READ_SEL == HOLD_LATCHED && BUFFER_FLAGS_READ && buf_rise == '0
    |=> BUFFER_READY_EVENT_FLAGS == '0)
    else $error("buffer flags survive a status read");

  pin_a_level_a: assert property (PIN_A_DRIVE_TYPE_SEL == DRV_PUSH_PULL
    |=> IRQ_PIN_A_OUT == ((|({BUFFER_READY_EVENT_FLAGS, FEATURE_EVENT_FLAGS} & $past(PIN_A_ROUTE_BITS)))
                          ~^ $past(PIN_A_POLARITY)))
    else $error("pin a level does not follow its routed flags");

  pin_b_route_a: assert property (PIN_B_ROUTE_BITS == '0 && PIN_B_DRIVE_TYPE_SEL == DRV_OPEN_DRAIN
    |=> IRQ_PIN_B_OE == ($past(PIN_B_DRIVE_ENABLE) && $past(PIN_B_POLARITY)))
    else $error("unrouted pin b leaves its idle level");

endmodule : mia_motion_irq

// ==== bench/mia_host_model.sv ====
// host side model: resolves both interrupt lines and can drive line b itself
// assumes board pull-ups on both lines and a testbench that sequences status reads
`timescale 1ns/1ps
module mia_host_model
(
  input  wire logic a_out,
  input  wire logic a_oe,
  input  wire logic b_out,
  input  wire logic b_oe,
  input  wire logic b_ext_en,
  input  wire logic b_ext_lvl,
  output logic      a_wire,
  output logic      b_wire
);
  // a released line goes to the pull-up level, never to the last driven value
  assign a_wire = a_oe ? a_out : 1'h1;
  // host drives line b only while the device leaves it; contention is not modelled
  assign b_wire = b_oe ? b_out : (b_ext_en ? b_ext_lvl : 1'h1);
endmodule : mia_host_model

// ==== bench/mia_motion_irq_tb.sv ====
// self-checking bench for the motion interrupt unit: samples, status reads, pins
// assumes default widths and a host model resolving both lines with pull-ups
`timescale 1ns/1ps
module mia_motion_irq_tb;
  import mia_pkg::*;
  logic CLK, RESET_N, SAMPLE_VALID, HOLD_UNTIL_READ_SEL, FEATURE_FLAGS_READ, BUFFER_FLAGS_READ;
  logic [15:0] ACC_X, ACC_Y, ACC_Z, ACT_THRESHOLD, STILL_THRESHOLD;
  logic [12:0] ACT_DURATION, STILL_DURATION;
  logic ACT_FIRST_AXIS_ARM, ACT_SECOND_AXIS_ARM, ACT_THIRD_AXIS_ARM;
  logic STILL_FIRST_AXIS_ARM, STILL_SECOND_AXIS_ARM, STILL_THIRD_AXIS_ARM;
  logic BUF_FULL_COND, BUF_WATERMARK_COND, SAMPLE_READY_COND;
  logic [EV_N-1:0] PIN_A_ROUTE_BITS, PIN_B_ROUTE_BITS;
  logic PIN_A_DRIVE_ENABLE, PIN_A_DRIVE_TYPE_SEL, PIN_A_POLARITY, PIN_A_SENSE_ENABLE, PIN_A_SENSE_TRIGGER_TYPE;
  logic PIN_B_DRIVE_ENABLE, PIN_B_DRIVE_TYPE_SEL, PIN_B_POLARITY, PIN_B_SENSE_ENABLE, PIN_B_SENSE_TRIGGER_TYPE;
  logic IRQ_PIN_A_IN, IRQ_PIN_B_IN, IRQ_PIN_A_OUT, IRQ_PIN_A_OE, IRQ_PIN_B_OUT, IRQ_PIN_B_OE;
  logic PIN_A_SENSED, PIN_B_SENSED;
  logic [FEAT_N-1:0] FEATURE_EVENT_FLAGS;
  logic [BUF_N-1:0]  BUFFER_READY_EVENT_FLAGS;
  logic [2:0]        bufc;
  logic              ext_en, ext_lvl;
  int                error_cnt, total_checks, n;
  assign {SAMPLE_READY_COND, BUF_WATERMARK_COND, BUF_FULL_COND} = bufc;

  mia_motion_irq mia_motion_irq_i (.CLK, .RESET_N, .SAMPLE_VALID, .ACC_X, .ACC_Y, .ACC_Z, .ACT_THRESHOLD,
    .ACT_DURATION, .ACT_FIRST_AXIS_ARM, .ACT_SECOND_AXIS_ARM, .ACT_THIRD_AXIS_ARM, .STILL_THRESHOLD,
    .STILL_DURATION, .STILL_FIRST_AXIS_ARM, .STILL_SECOND_AXIS_ARM, .STILL_THIRD_AXIS_ARM, .BUF_FULL_COND,
    .BUF_WATERMARK_COND, .SAMPLE_READY_COND, .HOLD_UNTIL_READ_SEL, .FEATURE_FLAGS_READ, .BUFFER_FLAGS_READ,
    .PIN_A_ROUTE_BITS, .PIN_B_ROUTE_BITS, .PIN_A_DRIVE_ENABLE, .PIN_A_DRIVE_TYPE_SEL, .PIN_A_POLARITY,
    .PIN_A_SENSE_ENABLE, .PIN_A_SENSE_TRIGGER_TYPE, .PIN_B_DRIVE_ENABLE, .PIN_B_DRIVE_TYPE_SEL,
    .PIN_B_POLARITY, .PIN_B_SENSE_ENABLE, .PIN_B_SENSE_TRIGGER_TYPE, .IRQ_PIN_A_IN, .IRQ_PIN_B_IN,
    .IRQ_PIN_A_OUT, .IRQ_PIN_A_OE, .IRQ_PIN_B_OUT, .IRQ_PIN_B_OE, .PIN_A_SENSED, .PIN_B_SENSED,
    .FEATURE_EVENT_FLAGS, .BUFFER_READY_EVENT_FLAGS);

  mia_host_model mia_host_model_i (.a_out(IRQ_PIN_A_OUT), .a_oe(IRQ_PIN_A_OE), .b_out(IRQ_PIN_B_OUT),
    .b_oe(IRQ_PIN_B_OE), .b_ext_en(ext_en), .b_ext_lvl(ext_lvl), .a_wire(IRQ_PIN_A_IN), .b_wire(IRQ_PIN_B_IN));

  always #12.5 CLK = ~CLK;

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one sample, then feature flags and line a (active high, push-pull) one cycle later
  task sf(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z, input logic [1:0] e);
    @(posedge CLK);
    SAMPLE_VALID <= 1'h1;
    ACC_X <= x;
    ACC_Y <= y;
    ACC_Z <= z;
    @(posedge CLK);
    SAMPLE_VALID <= 1'h0;
    #1;
    chk("feature_flags", {14'h0, e}, {14'h0, FEATURE_EVENT_FLAGS});
    chk("pin_a_level", {15'h0, |e}, {15'h0, IRQ_PIN_A_IN});
  endtask : sf

  task rdf;
    @(posedge CLK);
    FEATURE_FLAGS_READ <= 1'h1;
    @(posedge CLK);
    FEATURE_FLAGS_READ <= 1'h0;
    #1;
    chk("feature_flags", 16'h0000, {14'h0, FEATURE_EVENT_FLAGS});
    chk("pin_a_level", 16'h0000, {15'h0, IRQ_PIN_A_IN});
  endtask : rdf

  task rdb;
    @(posedge CLK);
    BUFFER_FLAGS_READ <= 1'h1;
    @(posedge CLK);
    BUFFER_FLAGS_READ <= 1'h0;
    #1;
  endtask : rdb

  task bset(input int i, input logic v);
    @(posedge CLK);
    bufc[i] <= v;
    @(posedge CLK);
    #1;
  endtask : bset

  // line b is open drain and active low: asserted pulls low, idle is released
  task chkb(input logic [2:0] e, input logic a);
    chk("buffer_flags", {13'h0, e}, {13'h0, BUFFER_READY_EVENT_FLAGS});
    chk("pin_b_level", {15'h0, ~a}, {15'h0, IRQ_PIN_B_IN});
    chk("pin_b_oe", {15'h0, a}, {15'h0, IRQ_PIN_B_OE});
  endtask : chkb

  task summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // the sequence needs well under 400 cycles
  initial
  begin
    repeat (2000) @(posedge CLK);
    error_cnt++;
    summarize();
  end

  initial
  begin
    CLK = 1'h0; RESET_N = 1'h0; SAMPLE_VALID = 1'h0; ACC_X = 16'h0000; ACC_Y = 16'h0000; ACC_Z = 16'h0000;
    ACT_THRESHOLD = 16'h0064; ACT_DURATION = 13'h0002; STILL_THRESHOLD = 16'h0014; STILL_DURATION = 13'h0003;
    ACT_FIRST_AXIS_ARM = 1'h1; ACT_SECOND_AXIS_ARM = 1'h0; ACT_THIRD_AXIS_ARM = 1'h0;
    STILL_FIRST_AXIS_ARM = 1'h0; STILL_SECOND_AXIS_ARM = 1'h0; STILL_THIRD_AXIS_ARM = 1'h0;
    bufc = 3'h0; HOLD_UNTIL_READ_SEL = 1'h1; FEATURE_FLAGS_READ = 1'h0; BUFFER_FLAGS_READ = 1'h0;
    PIN_A_ROUTE_BITS = 5'h03; PIN_B_ROUTE_BITS = 5'h1C;
    PIN_A_DRIVE_ENABLE = 1'h1; PIN_A_DRIVE_TYPE_SEL = 1'h0; PIN_A_POLARITY = 1'h1;
    PIN_A_SENSE_ENABLE = 1'h1; PIN_A_SENSE_TRIGGER_TYPE = 1'h0;
    PIN_B_DRIVE_ENABLE = 1'h1; PIN_B_DRIVE_TYPE_SEL = 1'h1; PIN_B_POLARITY = 1'h0;
    PIN_B_SENSE_ENABLE = 1'h1; PIN_B_SENSE_TRIGGER_TYPE = 1'h1;
    ext_en = 1'h0; ext_lvl = 1'h1; error_cnt = 0; total_checks = 0;
    repeat (7) @(posedge CLK);
    #1 chk("pin_a_oe", 16'h0000, {15'h0, IRQ_PIN_A_OE});
    @(posedge CLK);
    RESET_N <= 1'h1;
    repeat (2) @(posedge CLK);
    #1 chk("pin_a_oe", 16'h0001, {15'h0, IRQ_PIN_A_OE});
    chk("pin_a_level", 16'h0000, {15'h0, IRQ_PIN_A_IN});
    chkb(3'h0, 1'h0);
    // activity: slope equal to threshold is not enough, unarmed y is ignored
    sf(16'h0064, 16'h7000, 16'h0000, 2'h0);
    sf(16'h00C8, 16'h0000, 16'h0000, 2'h0);
    sf(16'h00C8, 16'h0000, 16'h0000, 2'h1);
    sf(16'h00D2, 16'h0000, 16'h0000, 2'h0);
    sf(16'h00FA, 16'h0000, 16'h0000, 2'h0);
    sf(16'h0140, 16'h0000, 16'h0000, 2'h0);
    sf(16'h0140, 16'h0000, 16'h0000, 2'h1);
    rdf();
    sf(16'h0140, 16'h0000, 16'h0000, 2'h0);
    sf(16'h0064, 16'h0000, 16'h0000, 2'h0);
    sf(16'h0064, 16'h0000, 16'h0000, 2'h1);
    @(posedge CLK);
    PIN_A_DRIVE_ENABLE <= 1'h0;
    repeat (2) @(posedge CLK);
    #1 chk("pin_a_oe", 16'h0000, {15'h0, IRQ_PIN_A_OE});
    @(posedge CLK);
    PIN_A_DRIVE_ENABLE <= 1'h1;
    repeat (3) @(posedge CLK);
    #1 chk("pin_a_sensed", 16'h0001, {15'h0, PIN_A_SENSED});
    rdf();
    repeat (3) @(posedge CLK);
    #1 chk("pin_a_sensed", 16'h0000, {15'h0, PIN_A_SENSED});
    // stillness on x only; z swings wildly but is not armed
    @(posedge CLK);
    ACT_FIRST_AXIS_ARM <= 1'h0;
    STILL_FIRST_AXIS_ARM <= 1'h1;
    sf(16'h0069, 16'h0000, 16'h0000, 2'h0);
    sf(16'h006E, 16'h0000, 16'h0000, 2'h0);
    sf(16'h0082, 16'h0000, 16'h0000, 2'h0);
    sf(16'h007D, 16'h0000, 16'h4000, 2'h0);
    sf(16'h0082, 16'h0000, 16'h0000, 2'h0);
    sf(16'h007D, 16'h0000, 16'h4000, 2'h2);
    sf(16'h009B, 16'h0000, 16'h0000, 2'h0);
    for (int i = 0; i < 3; i++)
    begin
      bset(i, 1'h1);
      chkb(3'h1 << i, 1'h1);
      rdb();
      chkb(3'h0, 1'h0);
      repeat (2) @(posedge CLK);
      #1 chkb(3'h0, 1'h0);
      bset(i, 1'h0);
      bset(i, 1'h1);
      chkb(3'h1 << i, 1'h1);
      rdb();
      bset(i, 1'h0);
    end
    @(posedge CLK);
    HOLD_UNTIL_READ_SEL <= 1'h0;
    for (int i = 0; i < 3; i++)
    begin
      bset(i, 1'h1);
      chkb(3'h1 << i, 1'h1);
      bset(i, 1'h0);
      chkb(3'h0, 1'h0);
    end
    @(posedge CLK);
    PIN_B_ROUTE_BITS <= 5'h00;
    bset(2, 1'h1);
    chkb(3'h4, 1'h0);
    bset(2, 1'h0);
    // line b as input only: the host pulls it to the asserted (low) level
    @(posedge CLK);
    PIN_B_DRIVE_ENABLE <= 1'h0;
    ext_en <= 1'h1;
    repeat (5) @(posedge CLK);
    ext_lvl <= 1'h0;
    n = 0;
    repeat (8)
    begin
      @(posedge CLK);
      #1 n += (PIN_B_SENSED === 1'h1) ? 1 : 0;
    end
    chk("pin_b_pulses", 16'h0001, n[15:0]);
    @(posedge CLK);
    PIN_B_SENSE_TRIGGER_TYPE <= 1'h0;
    repeat (4) @(posedge CLK);
    #1 chk("pin_b_sensed", 16'h0001, {15'h0, PIN_B_SENSED});
    @(posedge CLK);
    ext_lvl <= 1'h1;
    repeat (4) @(posedge CLK);
    #1 chk("pin_b_sensed", 16'h0000, {15'h0, PIN_B_SENSED});
    summarize();
  end
endmodule : mia_motion_irq_tb
